// File: design/alf_config_bank.sv
// APB register bank for the PLL loop filter, reference and feedback setup
`timescale 1ns/1ps
`default_nettype none
`include "alf_params.svh"
module alf_config_bank
	import alf_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [15:0] lock_loss_count_i,
	output alf_filter_cfg_t filter_cfg_o,
	output alf_refclk_cfg_t refclk_cfg_o,
	output logic [3:0] ref_route_onehot_o,
	output logic feedback_divider_enable_o,
	output logic zero_delay_mode_o,
	output logic lock_loss_limit_o
);
	// -----------------------------------------
	// Register state
	// -----------------------------------------
	logic [7:0] lpf_r;
	logic [7:0] lpf_nxt;
	logic [7:0] p3_r;
	logic [7:0] p3_nxt;
	logic [7:0] rfb_r;
	logic [7:0] rfb_nxt;
	logic [31:0] rdata_nxt;
	logic err_nxt;
	logic acc;
	logic wr;
	logic hit;
	logic xfer;
	logic rdy_r;
	logic rdy_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic err_r;

	function automatic logic known_addr(input logic [11:0] a);
		known_addr = (a == `ALF_OFF_LOOP_FILTER) ||
			(a == `ALF_OFF_THIRD_POLE) || (a == `ALF_OFF_REF_FB) ||
			(a == `ALF_OFF_LOCK_COUNT);
	endfunction

	assign acc = psel_i && penable_i;
	assign hit = known_addr(paddr_i);
	assign xfer = acc && rdy_r;
	assign wr = xfer && pwrite_i && pstrb_i[0] && hit;

	// -----------------------------------------
	// Next-state and read mux
	// -----------------------------------------
	always_comb begin
		lpf_nxt = lpf_r;
		p3_nxt = p3_r;
		rfb_nxt = rfb_r;
		if (wr && paddr_i == `ALF_OFF_LOOP_FILTER) begin
			lpf_nxt = pwdata_i[7:0];
		end
		if (wr && paddr_i == `ALF_OFF_THIRD_POLE) begin
			p3_nxt = pwdata_i[7:0] & `ALF_P3_WMASK;
		end
		if (wr && paddr_i == `ALF_OFF_REF_FB) begin
			rfb_nxt = pwdata_i[7:0];
		end
		rdata_nxt = 32'h0000_0000;
		case (paddr_i)
			`ALF_OFF_LOOP_FILTER: rdata_nxt = {24'h000000, lpf_r};
			`ALF_OFF_THIRD_POLE: rdata_nxt = {24'h000000, p3_r};
			`ALF_OFF_REF_FB: rdata_nxt = {24'h000000, rfb_r};
			`ALF_OFF_LOCK_COUNT: rdata_nxt = {15'h0000, lock_loss_limit_o,
				lock_loss_count_i};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			lpf_r <= `ALF_RST_LOOP_FILTER;
			p3_r <= `ALF_RST_THIRD_POLE;
			rfb_r <= `ALF_RST_REF_FB;
		end else begin
			lpf_r <= lpf_nxt;
			p3_r <= p3_nxt;
			rfb_r <= rfb_nxt;
		end
	end

	// -----------------------------------------
	// Bus answer
	// -----------------------------------------
	// One wait state so read data and error come from flops
	always_comb begin
		rdy_nxt = acc && !rdy_r;
		prdata_nxt = 32'h0000_0000;
		if (rdy_nxt) begin
			prdata_nxt = rdata_nxt;
		end
		err_nxt = rdy_nxt && !hit;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			rdy_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else begin
			rdy_r <= rdy_nxt;
			prdata_r <= prdata_nxt;
			err_r <= err_nxt;
		end
	end

	assign pready_o = rdy_r;
	assign prdata_o = prdata_r;
	assign pslverr_o = err_r;

	// -----------------------------------------
	// Field outputs
	// -----------------------------------------
	always_comb begin
		filter_cfg_o.vco_filter_bypass = lpf_r[`ALF_VCO_BYP_BIT];
		filter_cfg_o.pole_capacitor_code =
			lpf_r[`ALF_POLE_CAP_HI:`ALF_POLE_CAP_LO];
		filter_cfg_o.loop_resistor_code =
			lpf_r[`ALF_LPF_RES_HI:`ALF_LPF_RES_LO];
		filter_cfg_o.third_pole_bypass = p3_r[`ALF_P3_BYP_BIT];
		filter_cfg_o.third_pole_resistor_code =
			p3_r[`ALF_P3_RES_HI:`ALF_P3_RES_LO];
		filter_cfg_o.third_pole_capacitor_code =
			p3_r[`ALF_P3_CAP_HI:`ALF_P3_CAP_LO];
		refclk_cfg_o.lock_loss_threshold =
			rfb_r[`ALF_LOL_THR_HI:`ALF_LOL_THR_LO];
		refclk_cfg_o.feedback_divider_disable = rfb_r[`ALF_FB_DIS_BIT];
		refclk_cfg_o.feedback_source_select =
			alf_fb_sel_t'(rfb_r[`ALF_FB_SEL_BIT]);
		refclk_cfg_o.reference_select =
			alf_ref_sel_t'(rfb_r[`ALF_REF_SEL_HI:`ALF_REF_SEL_LO]);
	end

	alf_ref_mux u_ref_mux (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.cfg_i(refclk_cfg_o),
		.lock_loss_count_i(lock_loss_count_i),
		.ref_route_onehot_o(ref_route_onehot_o),
		.feedback_divider_enable_o(feedback_divider_enable_o),
		.zero_delay_mode_o(zero_delay_mode_o),
		.lock_loss_limit_o(lock_loss_limit_o)
	);

	// -----------------------------------------
	// Assertions
	// -----------------------------------------
	a_p3_rsvd_zero: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i) p3_r[`ALF_P3_RSVD_BIT] == 1'b0)
		else $error("reserved bit set");
	a_lpf_reset_val: assert property (@(posedge clk_sys_i)
		!rst_b_i |=> lpf_r == 8'h74)
		else $error("loop filter reset wrong");
	a_p3_reset_val: assert property (@(posedge clk_sys_i)
		!rst_b_i |=> p3_r == 8'h44)
		else $error("third pole reset wrong");
	a_lpf_write_takes: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		wr && paddr_i == `ALF_OFF_LOOP_FILTER |=>
		filter_cfg_o.vco_filter_bypass == $past(pwdata_i[7]) &&
		filter_cfg_o.loop_resistor_code == $past(pwdata_i[3:0]))
		else $error("loop filter write lost");
	a_p3_cap_write: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		wr && paddr_i == `ALF_OFF_THIRD_POLE |=>
		filter_cfg_o.third_pole_capacitor_code == $past(pwdata_i[2:0]))
		else $error("third pole capacitor write lost");
	a_fb_div_enable: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		$stable(rfb_r) |=> feedback_divider_enable_o ==
		!$past(rfb_r[`ALF_FB_DIS_BIT]))
		else $error("divider enable wrong");
	a_zero_delay_sel: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		$stable(rfb_r) |=>
		zero_delay_mode_o == $past(rfb_r[`ALF_FB_SEL_BIT]))
		else $error("feedback source wrong");
	a_rsvd_reads_zero: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		pready_o && !pwrite_i && paddr_i == `ALF_OFF_THIRD_POLE |->
		prdata_o[3] == 1'b0 && prdata_o[31:8] == 24'h000000)
		else $error("reserved read nonzero");
	a_unmapped_error: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		acc && !hit && pready_o |-> pslverr_o)
		else $error("unmapped access not flagged");

	a_rfb_reset_val: assert property (@(posedge clk_sys_i)
		!rst_b_i |=> rfb_r == `ALF_RST_REF_FB)
		else $error("ref fb reset wrong");

	a_pole_cap_write: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		wr && paddr_i == `ALF_OFF_LOOP_FILTER |=>
		filter_cfg_o.pole_capacitor_code == $past(pwdata_i[6:4]))
		else $error("pole capacitor write lost");

	a_p3_res_write: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		wr && paddr_i == `ALF_OFF_THIRD_POLE |=>
		filter_cfg_o.third_pole_resistor_code == $past(pwdata_i[6:4]))
		else $error("third pole resistor write lost");

	a_p3_byp_write: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		wr && paddr_i == `ALF_OFF_THIRD_POLE |=>
		filter_cfg_o.third_pole_bypass == $past(pwdata_i[7]))
		else $error("third pole bypass write lost");

	a_thr_write: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		wr && paddr_i == `ALF_OFF_REF_FB |=>
		refclk_cfg_o.lock_loss_threshold == $past(pwdata_i[7:4]))
		else $error("threshold write lost");

	a_fb_dis_write: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		wr && paddr_i == `ALF_OFF_REF_FB |=>
		refclk_cfg_o.feedback_divider_disable == $past(pwdata_i[3]))
		else $error("divider disable write lost");

	a_fb_sel_write: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		wr && paddr_i == `ALF_OFF_REF_FB |=>
		refclk_cfg_o.feedback_source_select == $past(pwdata_i[2]))
		else $error("feedback select write lost");

	a_ref_sel_write: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		wr && paddr_i == `ALF_OFF_REF_FB |=>
		refclk_cfg_o.reference_select == $past(pwdata_i[1:0]))
		else $error("reference select write lost");

	a_rsvd_write_drop: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		wr && paddr_i == `ALF_OFF_THIRD_POLE |=>
		p3_r[`ALF_P3_RSVD_BIT] == 1'b0)
		else $error("reserved bit written");

	a_strobe_ignored: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		xfer && pwrite_i && !pstrb_i[0] |=>
		$stable(lpf_r) && $stable(p3_r) && $stable(rfb_r))
		else $error("write without strobe landed");

	a_status_wr_ignored: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		xfer && pwrite_i && paddr_i == `ALF_OFF_LOCK_COUNT |=>
		$stable(lpf_r) && $stable(p3_r) && $stable(rfb_r))
		else $error("status write landed");

	a_unmapped_wr_drop: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		xfer && pwrite_i && !hit |=>
		$stable(lpf_r) && $stable(p3_r) && $stable(rfb_r))
		else $error("unmapped write landed");

	a_ready_one_cycle: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		pready_o |=> !pready_o)
		else $error("ready held too long");

	a_ready_in_access: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		pready_o |-> acc)
		else $error("ready outside access");

	a_ready_follows: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		acc && !pready_o |=> pready_o)
		else $error("ready missing");

	a_err_with_ready: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		pslverr_o |-> pready_o)
		else $error("error without ready");

	a_idle_rdata_zero: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		!pready_o |-> prdata_o == 32'h0000_0000)
		else $error("read data outside answer");

	a_lpf_read_value: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		pready_o && !pwrite_i && paddr_i == `ALF_OFF_LOOP_FILTER |->
		prdata_o == {24'h000000, $past(lpf_r)})
		else $error("loop filter read wrong");

	a_p3_read_value: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		pready_o && !pwrite_i && paddr_i == `ALF_OFF_THIRD_POLE |->
		prdata_o == {24'h000000, $past(p3_r)})
		else $error("third pole read wrong");

	a_rfb_read_value: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		pready_o && !pwrite_i && paddr_i == `ALF_OFF_REF_FB |->
		prdata_o == {24'h000000, $past(rfb_r)})
		else $error("ref fb read wrong");

	a_status_read: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		pready_o && !pwrite_i && paddr_i == `ALF_OFF_LOCK_COUNT |->
		prdata_o[31:17] == 15'h0000 &&
		prdata_o[16] == $past(lock_loss_limit_o))
		else $error("status read wrong");

	a_route_onehot: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		$onehot(ref_route_onehot_o))
		else $error("route not one-hot");
endmodule
`default_nettype wire

// File: design/alf_params.svh
// Register offsets, field positions and reset values of the loop filter bank
`ifndef ALF_PARAMS_SVH
`define ALF_PARAMS_SVH
`define ALF_OFF_LOOP_FILTER 12'h000
`define ALF_OFF_THIRD_POLE 12'h004
`define ALF_OFF_REF_FB 12'h008
`define ALF_OFF_LOCK_COUNT 12'h00C
`define ALF_VCO_BYP_BIT 7
`define ALF_POLE_CAP_HI 6
`define ALF_POLE_CAP_LO 4
`define ALF_LPF_RES_HI 3
`define ALF_LPF_RES_LO 0
`define ALF_P3_BYP_BIT 7
`define ALF_P3_RES_HI 6
`define ALF_P3_RES_LO 4
`define ALF_P3_RSVD_BIT 3
`define ALF_P3_CAP_HI 2
`define ALF_P3_CAP_LO 0
`define ALF_LOL_THR_HI 7
`define ALF_LOL_THR_LO 4
`define ALF_FB_DIS_BIT 3
`define ALF_FB_SEL_BIT 2
`define ALF_REF_SEL_HI 1
`define ALF_REF_SEL_LO 0
`define ALF_RST_LOOP_FILTER 8'h74
`define ALF_RST_THIRD_POLE 8'h44
`define ALF_RST_REF_FB 8'h00
`define ALF_P3_WMASK 8'hF7
`endif

// File: design/alf_pkg.sv
// Types shared by the loop filter configuration bank
package alf_pkg;
	typedef enum logic [1:0] {
		ALF_REF_CRYSTAL = 2'h0,
		ALF_REF_INPUT_ZERO = 2'h1,
		ALF_REF_INPUT_ONE = 2'h2,
		ALF_REF_GROUND = 2'h3
	} alf_ref_sel_t;
	typedef enum logic {
		ALF_FB_INTERNAL = 1'h0,
		ALF_FB_EXTERNAL = 1'h1
	} alf_fb_sel_t;
	typedef struct packed {
		logic vco_filter_bypass;
		logic [2:0] pole_capacitor_code;
		logic [3:0] loop_resistor_code;
		logic third_pole_bypass;
		logic [2:0] third_pole_resistor_code;
		logic [2:0] third_pole_capacitor_code;
	} alf_filter_cfg_t;
	typedef struct packed {
		logic [3:0] lock_loss_threshold;
		logic feedback_divider_disable;
		alf_fb_sel_t feedback_source_select;
		alf_ref_sel_t reference_select;
	} alf_refclk_cfg_t;
endpackage

// File: design/alf_ref_mux.sv
// Reference selection decoder and loss-of-lock comparator
`timescale 1ns/1ps
`default_nettype none
module alf_ref_mux
	import alf_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input var alf_refclk_cfg_t cfg_i,
	input wire logic [15:0] lock_loss_count_i,
	output logic [3:0] ref_route_onehot_o,
	output logic feedback_divider_enable_o,
	output logic zero_delay_mode_o,
	output logic lock_loss_limit_o
);
	logic [3:0] route_nxt;
	logic fbd_en_nxt;
	logic zdb_nxt;
	logic lol_nxt;
	always_comb begin
		route_nxt = 4'h0;
		case (cfg_i.reference_select)
			ALF_REF_CRYSTAL: route_nxt = 4'h1;
			ALF_REF_INPUT_ZERO: route_nxt = 4'h2;
			ALF_REF_INPUT_ONE: route_nxt = 4'h4;
			ALF_REF_GROUND: route_nxt = 4'h8;
			default: route_nxt = 4'h8;
		endcase
		fbd_en_nxt = ~cfg_i.feedback_divider_disable;
		zdb_nxt = (cfg_i.feedback_source_select == ALF_FB_EXTERNAL);
		lol_nxt = lock_loss_count_i > {12'h000, cfg_i.lock_loss_threshold};
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			ref_route_onehot_o <= 4'h1;
			feedback_divider_enable_o <= 1'b1;
			zero_delay_mode_o <= 1'b0;
			lock_loss_limit_o <= 1'b0;
		end else begin
			ref_route_onehot_o <= route_nxt;
			feedback_divider_enable_o <= fbd_en_nxt;
			zero_delay_mode_o <= zdb_nxt;
			lock_loss_limit_o <= lol_nxt;
		end
	end
	a_lol_tracks_count: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		$stable(lock_loss_count_i) && $stable(cfg_i) |=>
		lock_loss_limit_o == ($past(lock_loss_count_i) >
		{12'h000, $past(cfg_i.lock_loss_threshold)}))
		else $error("lock loss flag wrong");
	a_ref_ground_route: assert property (@(posedge clk_sys_i)
		disable iff (!rst_b_i)
		cfg_i.reference_select == ALF_REF_GROUND |=>
		ref_route_onehot_o == 4'h8)
		else $error("ground route missing");
endmodule
`default_nettype wire

// File: testbench/alf_config_bank_tb.sv
// Self-checking bench for the loop filter configuration bank
`timescale 1ns/1ps
`default_nettype none
module alf_config_bank_tb
	import alf_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [15:0] cnt = 16'h0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	alf_filter_cfg_t fcfg;
	alf_refclk_cfg_t rcfg;
	logic [3:0] route;
	logic fben;
	logic zdm;
	logic lim;
	int miscompares = 0;
	int checked = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	alf_config_bank i_dut (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
		.pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr),
		.lock_loss_count_i(cnt), .filter_cfg_o(fcfg),
		.refclk_cfg_o(rcfg), .ref_route_onehot_o(route),
		.feedback_divider_enable_o(fben), .zero_delay_mode_o(zdm),
		.lock_loss_limit_o(lim)
	);

	// ----------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------
	task automatic summarize();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic er);
		int n;
		@(posedge clk_sys_i);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk_sys_i);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			miscompares++;
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		logic er;
		apb(1'b1, a, d, s, r, er);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
		logic [31:0] r;
		logic er;
		apb(1'b0, a, 32'h0, 4'h0, r, er);
		chk("rdata", e, r);
		chk("slverr", {31'h0, ee}, {31'h0, er});
	endtask

	task automatic settle();
		repeat (2) @(posedge clk_sys_i);
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		logic [7:0] b;
		repeat (8) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		rd(12'h000, 32'h74, 1'b0);
		rd(12'h004, 32'h44, 1'b0);
		rd(12'h008, 32'h00, 1'b0);
		chk("route", 32'h1, {28'h0, route});
		chk("fben", 32'h1, {31'h0, fben});
		chk("zdm", 32'h0, {31'h0, zdm});
		chk("lim", 32'h0, {31'h0, lim});
		wr(12'h000, 32'hFFFFFF8B, 4'hF);
		wr(12'h004, 32'hFFFFFFFF, 4'hF);
		settle();
		chk("fcfg", {17'h0, 1'b1, 3'h0, 4'hB, 1'b1, 3'h7, 3'h7}, {17'h0, fcfg});
		rd(12'h004, 32'hF7, 1'b0);
		wr(12'h000, 32'h00, 4'h0);
		wr(12'h00C, 32'hFFFFFFFF, 4'hF);
		wr(12'h010, 32'hFFFFFFFF, 4'hF);
		rd(12'h000, 32'h8B, 1'b0);
		for (int i = 0; i < 4; i++) begin
			b = {4'h0, i[0], i[1], i[1:0]};
			wr(12'h008, {24'h0, b}, 4'h1);
			settle();
			chk("rcfg", {24'h0, b}, {24'h0, rcfg});
			chk("route", 32'h1 << i, {28'h0, route});
			chk("fben", {31'h0, ~i[0]}, {31'h0, fben});
			chk("zdm", {31'h0, i[1]}, {31'h0, zdm});
		end
		for (int t = 0; t < 16; t += 15) begin
			wr(12'h008, {24'h0, 4'(t), 4'h0}, 4'h1);
			for (int d = 0; d < 2; d++) begin
				cnt <= 16'(t + d);
				settle();
				chk("lim", 32'(d), {31'h0, lim});
			end
		end
		rd(12'h00C, 32'h00010010, 1'b0);
		rd(12'h010, 32'h0, 1'b1);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		rd(12'h004, 32'h44, 1'b0);
		summarize();
	end

	initial begin
		repeat (3000) @(posedge clk_sys_i);
		miscompares++;
		summarize();
	end
endmodule
`default_nettype wire
